// ### hdl/eab_pkg.sv
// constants shared by the external area bus configuration block
package eab_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [23:0] IDX_PIN_CS = 24'hff_fbc0;
   localparam logic [23:0] IDX_PIN_STROBE = 24'hff_fbc2;
   localparam logic [23:0] IDX_PIN_UADDR = 24'hff_fbc4;
   localparam logic [23:0] IDX_PIN_BWR = 24'hff_fbc6;
   localparam logic [23:0] IDX_BUS_WIDTH = 24'hff_fd84;
   localparam logic [23:0] IDX_ACC_STATE = 24'hff_fd86;
   localparam logic [23:0] IDX_WAIT_B = 24'hff_fd8a;
   localparam logic [23:0] IDX_RD_NEG = 24'hff_fd8c;
   localparam logic [23:0] IDX_BYTE_ORDER = 24'hff_fd95;
   localparam logic [23:0] IDX_PORT_D_DIR = 24'hff_fb8c;
   localparam logic [23:0] IDX_PORT_E_DIR = 24'hff_fb8d;
   localparam logic [23:0] IDX_STATUS = 24'hff_fd98;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_HALF = 16'h0000;

   // field positions
   localparam int RW_STROBE_EN_BIT = 2;
   localparam int BWR_STROBE_EN_BIT = 6;
   localparam int UPPER_FIELD_LSB = 8;
   localparam int WAIT_A3_LSB = 12;
   localparam int WAIT_A2_LSB = 4;
   localparam int WAIT_W = 3;
   localparam logic [2:0] SRAM_AREA = 3'h3;

   // timing: cycles added to a read so pin data can cross two flops, and the extra strobe cycle of a three-state access
   localparam logic [3:0] READ_SYNC_CYCLES = 4'h2;
   localparam logic [3:0] THREE_STATE_EXTRA = 4'h1;

   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // access sequencer, gray coded along idle, t1, t2, end
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_T1 = 2'b01,
      ST_T2 = 2'b11,
      ST_END = 2'b10
   } eab_state_e;

endpackage : eab_pkg

// ### hdl/eab_lane_swap.sv
// byte lane exchange of one 16-bit word
`timescale 1ns/1ps
module eab_lane_swap
(
   // data
   input wire logic [15:0] din,
   input wire logic swap,
   output logic [15:0] dout
);
   assign dout = swap ? {din[7:0], din[15:8]} : din;
endmodule : eab_lane_swap

// ### hdl/eab_wait_ctr.sv
// loadable down counter timing the strobe state of an access
`timescale 1ns/1ps
module eab_wait_ctr
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control
   input wire logic load,
   input wire logic [3:0] load_val,
   // state
   output logic [3:0] cnt_r,
   output logic zero
);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cnt_r <= 4'h0;
      else if (load)
         cnt_r <= load_val;
      else if (cnt_r != 4'h0)
         cnt_r <= cnt_r - 4'h1;
   end
   assign zero = (cnt_r == 4'h0);
endmodule : eab_wait_ctr

// ### hdl/eab_bus_ctrl.sv
// external area bus controller with per-area byte order and pin setup
`timescale 1ns/1ps
module eab_bus_ctrl
   import eab_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // internal access request
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic acc_word,
   input wire logic [2:0] acc_area,
   input wire logic [20:0] acc_addr,
   input wire logic [15:0] acc_wdata,
   output logic acc_ready,
   output logic acc_done,
   output logic [15:0] acc_rdata,
   // external pins
   output logic [20:0] ext_addr,
   output logic [15:0] addr_lo_oe_n,
   output logic [4:0] addr_hi_oe_n,
   output logic [7:0] area_chip_select_n,
   output logic [7:0] chip_select_oe_n,
   output logic rd_n,
   output logic rw_strobe,
   output logic rw_strobe_oe_n,
   output logic hwr_n,
   output logic lower_high_byte_write_strobe_n,
   output logic port_a_bit4_oe_n,
   input wire logic [15:0] ext_data_in,
   output logic [15:0] ext_data_out,
   output logic ext_data_oe_n
);
   import eab_pkg::*;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic [7:0] pin_func_chip_select_r;
   logic [7:0] pin_func_strobe_r;
   logic [7:0] pin_func_upper_address_r;
   logic [7:0] pin_func_byte_write_r;
   logic [15:0] area_bus_width_ctrl_r;
   logic [15:0] area_access_state_ctrl_r;
   logic [15:0] area_wait_count_b_r;
   logic [15:0] read_strobe_negate_timing_r;
   logic [7:0] area_byte_order_select_r;
   logic [7:0] port_d_direction_r;
   logic [7:0] port_e_direction_r;
   logic [31:0] status_word;
   logic [31:0] rd_mux;

   // ------------------------------------------------------------
   // ahb-lite slave, zero wait
   // ------------------------------------------------------------
   logic addr_ok;
   logic [23:0] idx;
   logic wr_pend_r;
   logic [23:0] wr_idx_r;
   logic [31:0] wr_val;
   logic [31:0] wr_mask;
   logic fwd;

   assign idx = haddr[25:2];
   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 24'h00_0000;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
      else
      begin
         wr_pend_r <= addr_ok && hwrite && (haddr[31:26] == 6'h00);
         wr_idx_r <= idx;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_func_chip_select_r <= RST_BYTE;
         pin_func_strobe_r <= RST_BYTE;
         pin_func_upper_address_r <= RST_BYTE;
         pin_func_byte_write_r <= RST_BYTE;
         area_bus_width_ctrl_r <= RST_HALF;
         area_access_state_ctrl_r <= RST_HALF;
         area_wait_count_b_r <= RST_HALF;
         read_strobe_negate_timing_r <= RST_HALF;
         area_byte_order_select_r <= RST_BYTE;
         port_d_direction_r <= RST_BYTE;
         port_e_direction_r <= RST_BYTE;
      end
      else if (wr_pend_r)
      begin
         case (wr_idx_r)
            IDX_PIN_CS: pin_func_chip_select_r <= hwdata[7:0];
            IDX_PIN_STROBE: pin_func_strobe_r <= hwdata[7:0];
            IDX_PIN_UADDR: pin_func_upper_address_r <= hwdata[7:0];
            IDX_PIN_BWR: pin_func_byte_write_r <= hwdata[7:0];
            IDX_BUS_WIDTH: area_bus_width_ctrl_r <= hwdata[15:0];
            IDX_ACC_STATE: area_access_state_ctrl_r <= hwdata[15:0];
            IDX_WAIT_B: area_wait_count_b_r <= hwdata[15:0];
            IDX_RD_NEG: read_strobe_negate_timing_r <= hwdata[15:0];
            IDX_BYTE_ORDER: area_byte_order_select_r <= hwdata[7:0];
            IDX_PORT_D_DIR: port_d_direction_r <= hwdata[7:0];
            IDX_PORT_E_DIR: port_e_direction_r <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   always_comb
   begin
      case (idx)
         IDX_PIN_CS: rd_mux = {24'h00_0000, pin_func_chip_select_r};
         IDX_PIN_STROBE: rd_mux = {24'h00_0000, pin_func_strobe_r};
         IDX_PIN_UADDR: rd_mux = {24'h00_0000, pin_func_upper_address_r};
         IDX_PIN_BWR: rd_mux = {24'h00_0000, pin_func_byte_write_r};
         IDX_BUS_WIDTH: rd_mux = {16'h0000, area_bus_width_ctrl_r};
         IDX_ACC_STATE: rd_mux = {16'h0000, area_access_state_ctrl_r};
         IDX_WAIT_B: rd_mux = {16'h0000, area_wait_count_b_r};
         IDX_RD_NEG: rd_mux = {16'h0000, read_strobe_negate_timing_r};
         IDX_BYTE_ORDER: rd_mux = {24'h00_0000, area_byte_order_select_r};
         IDX_PORT_D_DIR: rd_mux = {24'h00_0000, port_d_direction_r};
         IDX_PORT_E_DIR: rd_mux = {24'h00_0000, port_e_direction_r};
         IDX_STATUS: rd_mux = status_word;
         default: rd_mux = 32'h0000_0000;
      endcase
      if (haddr[31:26] != 6'h00)
         rd_mux = 32'h0000_0000;
   end

   // a read right behind a write to the same word sees the new data;
   // unmapped and read-only words forward nothing, so unmapped ones still read 0 and the status word its live value
   always_comb
   begin
      case (idx)
         IDX_BUS_WIDTH, IDX_ACC_STATE, IDX_WAIT_B, IDX_RD_NEG:
            wr_mask = 32'h0000_ffff;
         IDX_PIN_CS, IDX_PIN_STROBE, IDX_PIN_UADDR, IDX_PIN_BWR,
            IDX_BYTE_ORDER, IDX_PORT_D_DIR, IDX_PORT_E_DIR:
            wr_mask = 32'h0000_00ff;
         default: wr_mask = 32'h0000_0000;
      endcase
   end
   assign wr_val = hwdata & wr_mask;
   assign fwd = wr_pend_r && (wr_idx_r == idx)
      && (wr_mask != 32'h0000_0000) && (haddr[31:26] == 6'h00);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (addr_ok && !hwrite)
         hrdata <= fwd ? wr_val : rd_mux;
   end

   // ------------------------------------------------------------
   // access sequencer
   // ------------------------------------------------------------
   eab_state_e state_r;
   eab_state_e state_nxt;
   logic take;
   logic wr_r, word_r, le_r, bus16_r, early_r, pass_r;
   logic [2:0] area_r;
   logic [20:0] addr_r;
   logic [15:0] wdata_r;
   logic [3:0] dwell;
   logic [2:0] waits;
   logic [3:0] cnt;
   logic cnt_zero;
   logic last_pass;

   assign take = (state_r == ST_IDLE) && acc_valid && acc_ready;
   assign last_pass = bus16_r || !word_r || pass_r;

   // waits come only from register b, which covers areas three and two
   always_comb
   begin
      case (area_r)
         SRAM_AREA: waits = area_wait_count_b_r[WAIT_A3_LSB +: WAIT_W];
         3'h2: waits = area_wait_count_b_r[WAIT_A2_LSB +: WAIT_W];
         default: waits = 3'h0;
      endcase
      dwell = (area_access_state_ctrl_r[UPPER_FIELD_LSB + area_r]
         ? THREE_STATE_EXTRA + {1'b0, waits} : 4'h0)
         + (wr_r ? 4'h0 : READ_SYNC_CYCLES);
   end

   always_comb
   begin
      case (state_r)
         ST_IDLE: state_nxt = take ? ST_T1 : ST_IDLE;
         ST_T1: state_nxt = ST_T2;
         ST_T2: state_nxt = cnt_zero ? ST_END : ST_T2;
         ST_END: state_nxt = last_pass ? ST_IDLE : ST_T1;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // request fields and the byte order, width and read negate settings are frozen for the whole access
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {wr_r, word_r, le_r, bus16_r, early_r, pass_r} <= 6'h00;
         area_r <= 3'h0;
         addr_r <= 21'h00_0000;
         wdata_r <= 16'h0000;
      end
      else if (take)
      begin
         wr_r <= acc_write;
         word_r <= acc_word;
         area_r <= acc_area;
         addr_r <= acc_addr;
         wdata_r <= acc_wdata;
         pass_r <= 1'b0;
         le_r <= area_byte_order_select_r[acc_area];
         bus16_r <= !area_bus_width_ctrl_r[UPPER_FIELD_LSB + acc_area];
         early_r <= read_strobe_negate_timing_r[acc_area];
      end
      else if (state_r == ST_END)
         pass_r <= 1'b1;
   end

   eab_wait_ctr u_wait
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(state_r == ST_T1),
      .load_val(dwell),
      .cnt_r(cnt),
      .zero(cnt_zero)
   );

   // ------------------------------------------------------------
   // data lanes and byte order
   // ------------------------------------------------------------
   logic [15:0] din_s1_r, din_s2_r;
   logic [15:0] lane_w, rd_word, rd_cpu;
   logic [7:0] rbuf_hi_r;
   logic odd;

   assign odd = addr_r[0];

   // only the second flop is read anywhere
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         din_s1_r <= 16'h0000;
         din_s2_r <= 16'h0000;
      end
      else
      begin
         din_s1_r <= ext_data_in;
         din_s2_r <= din_s1_r;
      end
   end

   // cpu words are big endian; a little endian area trades the lanes
   eab_lane_swap u_wswap
   (
      .din(wdata_r),
      .swap(le_r && word_r),
      .dout(lane_w)
   );

   assign rd_word = bus16_r ? din_s2_r : {rbuf_hi_r, din_s2_r[15:8]};

   eab_lane_swap u_rswap
   (
      .din(rd_word),
      .swap(le_r && word_r),
      .dout(rd_cpu)
   );

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rbuf_hi_r <= 8'h00;
         acc_done <= 1'b0;
         acc_rdata <= 16'h0000;
         acc_ready <= 1'b0;
      end
      else
      begin
         acc_ready <= (state_nxt == ST_IDLE) && !take;
         acc_done <= (state_r == ST_END) && last_pass;
         if (state_r == ST_END && !wr_r)
         begin
            rbuf_hi_r <= din_s2_r[15:8];
            if (last_pass)
               acc_rdata <= word_r ? rd_cpu : {8'h00, (bus16_r && odd)
                  ? din_s2_r[7:0] : din_s2_r[15:8]};
         end
      end
   end

   // ------------------------------------------------------------
   // external pins, one cycle behind the sequencer state
   // ------------------------------------------------------------
   logic act;
   logic strobe;
   assign act = (state_r == ST_T1) || (state_r == ST_T2);
   assign strobe = (state_r == ST_T2);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ext_addr <= 21'h00_0000;
         area_chip_select_n <= 8'hff;
         rd_n <= 1'b1;
         rw_strobe <= 1'b1;
         hwr_n <= 1'b1;
         lower_high_byte_write_strobe_n <= 1'b1;
         ext_data_out <= 16'h0000;
         ext_data_oe_n <= 1'b1;
      end
      else
      begin
         ext_addr <= {addr_r[20:1], addr_r[0] | pass_r};
         area_chip_select_n <= act ? ~(8'h01 << area_r) : 8'hff;
         rd_n <= !(strobe && !wr_r && !(early_r && cnt_zero));
         rw_strobe <= !(act && wr_r);
         hwr_n <= !(strobe && wr_r && (!bus16_r || word_r || !odd));
         lower_high_byte_write_strobe_n <= !(strobe && wr_r && bus16_r
            && (word_r || odd));
         ext_data_oe_n <= !(strobe && wr_r);
         if (!word_r)
            ext_data_out <= {wdata_r[7:0], wdata_r[7:0]};
         else if (bus16_r)
            ext_data_out <= lane_w;
         else
            ext_data_out <= {pass_r ? lane_w[7:0] : lane_w[15:8], 8'h00};
      end
   end

   // pin function: enable low while the block owns the pin
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         chip_select_oe_n <= 8'hff;
         rw_strobe_oe_n <= 1'b1;
         addr_hi_oe_n <= 5'h1f;
         port_a_bit4_oe_n <= 1'b1;
         addr_lo_oe_n <= 16'hffff;
      end
      else
      begin
         chip_select_oe_n <= ~pin_func_chip_select_r;
         rw_strobe_oe_n <= !pin_func_strobe_r[RW_STROBE_EN_BIT];
         addr_hi_oe_n <= ~pin_func_upper_address_r[4:0];
         port_a_bit4_oe_n <= !pin_func_byte_write_r[BWR_STROBE_EN_BIT];
         addr_lo_oe_n <= ~{port_e_direction_r, port_d_direction_r};
      end
   end

   assign status_word = {26'h000_0000, le_r, area_r, bus16_r,
      state_r != ST_IDLE};

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [4:0] t2_len_r;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         t2_len_r <= 5'h00;
      else
         t2_len_r <= strobe ? t2_len_r + 5'h01 : 5'h00;
   end

   sequence s_t1_read_area3;
      state_r == ST_T1 && !wr_r && area_r == SRAM_AREA && !pass_r;
   endsequence

   a_t2_dwell_len: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == ST_T2 && cnt_zero && wr_r && area_r == SRAM_AREA
      && area_access_state_ctrl_r[UPPER_FIELD_LSB + 3]) |->
      t2_len_r == {2'b00, area_wait_count_b_r[WAIT_A3_LSB +: WAIT_W]}
      + {1'b0, THREE_STATE_EXTRA})
      else $error("strobe state longer than the programmed wait");
   a_sram_cs_select: assert property (@(posedge hclk) disable iff (!hresetn)
      s_t1_read_area3 |=> ##1 area_chip_select_n == 8'hf7)
      else $error("area three chip select not driven");
   a_read_end_negate: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == ST_END && !wr_r) |=> rd_n)
      else $error("read strobe still low after cycle end");
   a_cs_oe_follow: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 chip_select_oe_n == ~$past(pin_func_chip_select_r))
      else $error("chip select enable does not follow register");
   a_rw_oe_follow: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 rw_strobe_oe_n == !$past(pin_func_strobe_r[2]))
      else $error("rw strobe enable wrong");
   a_addr_hi_oe: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 addr_hi_oe_n == ~$past(pin_func_upper_address_r[4:0]))
      else $error("upper address enables wrong");
   a_bwr_pin_oe: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 port_a_bit4_oe_n == !$past(pin_func_byte_write_r[6]))
      else $error("byte write strobe enable wrong");
   a_addr_lo_dir: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 addr_lo_oe_n == ~$past({port_e_direction_r, port_d_direction_r}))
      else $error("low address enables wrong");
   a_le_word_swap: assert property (@(posedge hclk) disable iff (!hresetn)
      (strobe && wr_r && word_r && le_r && bus16_r) |=>
      ext_data_out == {wdata_r[7:0], wdata_r[15:8]})
      else $error("little endian word not lane swapped");
   a_narrow_no_low: assert property (@(posedge hclk) disable iff (!hresetn)
      (strobe && !bus16_r) |=> lower_high_byte_write_strobe_n)
      else $error("low lane strobe on an 8-bit area");

endmodule : eab_bus_ctrl

// ### tb/eab_sram_model.sv
// behavioural external sram hanging on the area three chip select
`timescale 1ns/1ps
module eab_sram_model
(
   // clock
   input wire logic hclk,
   // bus pins
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic hwr_n,
   input wire logic lwr_n,
   input wire logic [20:0] addr,
   input wire logic [15:0] dout,
   output logic [15:0] din
);
   logic [15:0] mem [0:255];
   logic [15:0] junk_r = 16'h5a5a;
   // a released bus shows a moving pattern, so a late capture never
   // picks up a stale word by luck
   always @(posedge hclk)
      junk_r <= ~din;
   assign din = (!cs_n && !rd_n) ? mem[addr[8:1]] : junk_r;
   always @(posedge hclk)
   begin
      if (!cs_n && !hwr_n)
         mem[addr[8:1]][15:8] <= dout[15:8];
      if (!cs_n && !lwr_n)
         mem[addr[8:1]][7:0] <= dout[7:0];
   end
endmodule : eab_sram_model

// ### tb/testbench.sv
// self-checking bench for the external area bus configuration block
`timescale 1ns/1ps
module testbench;
   import eab_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   wire logic hready;
   logic [31:0] hrdata;
   logic hreadyout, hresp;
   logic acc_valid = 1'b0;
   logic acc_write = 1'b0;
   logic acc_word = 1'b1;
   logic [2:0] acc_area = 3'h3;
   logic [20:0] acc_addr = 21'h0_0000;
   logic [15:0] acc_wdata = 16'h0000;
   logic acc_ready, acc_done;
   logic [15:0] acc_rdata, ext_data_in, ext_data_out, addr_lo_oe_n;
   logic [20:0] ext_addr;
   logic [4:0] addr_hi_oe_n;
   logic [7:0] area_chip_select_n, chip_select_oe_n;
   logic rd_n, rw_strobe, rw_strobe_oe_n, hwr_n, lwr_n, pa4_oe_n;
   logic ext_data_oe_n;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   localparam logic [23:0] RIDX [0:10] = '{IDX_PIN_CS, IDX_PIN_STROBE,
      IDX_PIN_UADDR, IDX_PIN_BWR, IDX_BUS_WIDTH, IDX_ACC_STATE,
      IDX_WAIT_B, IDX_RD_NEG, IDX_BYTE_ORDER, IDX_PORT_D_DIR,
      IDX_PORT_E_DIR};
   localparam logic [31:0] RMSK [0:10] = '{32'h0000_00ff, 32'h0000_00ff,
      32'h0000_00ff, 32'h0000_00ff, 32'h0000_ffff, 32'h0000_ffff,
      32'h0000_ffff, 32'h0000_ffff, 32'h0000_00ff, 32'h0000_00ff,
      32'h0000_00ff};

   assign hready = hreadyout;
   always #2 hclk = ~hclk;

   eab_bus_ctrl eab_bus_ctrl_i
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .acc_valid(acc_valid), .acc_write(acc_write),
      .acc_word(acc_word), .acc_area(acc_area), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .acc_ready(acc_ready), .acc_done(acc_done),
      .acc_rdata(acc_rdata), .ext_addr(ext_addr),
      .addr_lo_oe_n(addr_lo_oe_n), .addr_hi_oe_n(addr_hi_oe_n),
      .area_chip_select_n(area_chip_select_n),
      .chip_select_oe_n(chip_select_oe_n), .rd_n(rd_n),
      .rw_strobe(rw_strobe), .rw_strobe_oe_n(rw_strobe_oe_n),
      .hwr_n(hwr_n), .lower_high_byte_write_strobe_n(lwr_n),
      .port_a_bit4_oe_n(pa4_oe_n), .ext_data_in(ext_data_in),
      .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n)
   );

   eab_sram_model eab_sram_model_i
   (
      .hclk(hclk), .cs_n(area_chip_select_n[3]), .rd_n(rd_n),
      .hwr_n(hwr_n), .lwr_n(lwr_n), .addr(ext_addr),
      .dout(ext_data_out), .din(ext_data_in)
   );

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk

   task automatic ahb(input logic [23:0] idx, input logic wr,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {6'h00, idx, 2'h0};
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      chk(32'(hresp), 32'(HRESP_OKAY));
   endtask : ahb

   task automatic wr(input logic [23:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      ahb(idx, 1'b1, wd, d);
   endtask : wr

   // counts cycles from the take edge until done is seen
   task automatic acc(input logic w, input logic [20:0] a,
      input logic [15:0] wd, output logic [15:0] rdat, output int n);
      logic prev_rd;
      logic cs_seen;
      logic rw_seen;
      logic oe_seen;
      @(posedge hclk);
      acc_valid <= 1'b1;
      acc_write <= w;
      acc_addr <= a;
      acc_wdata <= wd;
      do @(negedge hclk); while (acc_ready !== 1'b1);
      @(posedge hclk);
      acc_valid <= 1'b0;
      n = 0;
      prev_rd = 1'b1;
      cs_seen = 1'b0;
      rw_seen = 1'b0;
      oe_seen = 1'b0;
      do
      begin
         prev_rd = rd_n;
         @(negedge hclk);
         n++;
         if (area_chip_select_n[3] === 1'b0)
            cs_seen = 1'b1;
         if (rw_strobe === 1'b0)
            rw_seen = 1'b1;
         if (ext_data_oe_n === 1'b0)
            oe_seen = 1'b1;
      end while (acc_done !== 1'b1 && n < 100);
      rdat = acc_rdata;
      chk(32'(cs_seen), 32'h0000_0001);
      chk(32'({rw_seen, oe_seen}), {30'h0000_0000, w, w});
      if (!w)
         chk(32'({rd_n, prev_rd}), 32'h0000_0002);
   endtask : acc

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [31:0] r;
      for (int i = 0; i < 11; i++)
      begin
         ahb(RIDX[i], 1'b0, 32'h0000_0000, r);
         chk(r, 32'h0000_0000);
         wr(RIDX[i], 32'hffff_ffff);
         ahb(RIDX[i], 1'b0, 32'h0000_0000, r);
         chk(r, RMSK[i]);
         wr(RIDX[i], 32'h0000_0000);
      end
      wr(24'h00_0010, 32'hffff_ffff);
      ahb(24'h00_0010, 1'b0, 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
   endtask : t_regs

   task automatic t_pins(input logic [7:0] cs, input logic [7:0] st,
      input logic [7:0] ua, input logic [7:0] bw, input logic [7:0] dd,
      input logic [7:0] de);
      wr(IDX_PIN_CS, {24'h00_0000, cs});
      wr(IDX_PIN_STROBE, {24'h00_0000, st});
      wr(IDX_PIN_UADDR, {24'h00_0000, ua});
      wr(IDX_PIN_BWR, {24'h00_0000, bw});
      wr(IDX_PORT_D_DIR, {24'h00_0000, dd});
      wr(IDX_PORT_E_DIR, {24'h00_0000, de});
      repeat (3) @(negedge hclk);
      chk(32'(chip_select_oe_n), {24'h00_0000, ~cs});
      chk(32'(rw_strobe_oe_n), {31'h0000_0000, ~st[2]});
      chk(32'(addr_hi_oe_n), {27'h000_0000, ~ua[4:0]});
      chk(32'(pa4_oe_n), {31'h0000_0000, ~bw[6]});
      chk(32'(addr_lo_oe_n), 32'({~de, ~dd}));
   endtask : t_pins

   task automatic t_timing();
      logic [15:0] r;
      int n;
      wr(IDX_BUS_WIDTH, 32'h0000_00ff);
      wr(IDX_WAIT_B, 32'h0000_7000);
      wr(IDX_RD_NEG, 32'h0000_0000);
      acc(1'b1, 21'h0_0010, 16'hbeef, r, n);
      chk(32'(n), 32'h0000_0004);
      acc(1'b0, 21'h0_0010, 16'h0000, r, n);
      chk(32'(n), 32'h0000_0006);
      chk(32'(r), 32'h0000_beef);
      // three-state cycles plus seven waits on area three
      wr(IDX_ACC_STATE, 32'h0000_ff00);
      acc(1'b1, 21'h0_0012, 16'h5a0f, r, n);
      chk(32'(n), 32'h0000_000c);
      acc(1'b0, 21'h0_0012, 16'h0000, r, n);
      chk(32'(n), 32'h0000_000e);
      chk(32'(r), 32'h0000_5a0f);
   endtask : t_timing

   task automatic t_endian();
      logic [15:0] r;
      int n;
      wr(IDX_BYTE_ORDER, 32'h0000_0008);
      acc(1'b1, 21'h0_0020, 16'h1234, r, n);
      acc(1'b0, 21'h0_0020, 16'h0000, r, n);
      chk(32'(r), 32'h0000_1234);
      wr(IDX_BYTE_ORDER, 32'h0000_0000);
      acc(1'b0, 21'h0_0020, 16'h0000, r, n);
      chk(32'(r), 32'h0000_3412);
      // single bytes: odd byte rides the low lane, even byte the high one
      @(posedge hclk);
      acc_word <= 1'b0;
      acc(1'b1, 21'h0_0021, 16'h007e, r, n);
      acc(1'b0, 21'h0_0021, 16'h0000, r, n);
      chk(32'(r), 32'h0000_007e);
      acc(1'b0, 21'h0_0020, 16'h0000, r, n);
      chk(32'(r), 32'h0000_0034);
   endtask : t_endian

   task automatic tally_and_finish();
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   // the whole run needs well under two thousand cycles
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_pins(8'hf7, 8'hfb, 8'hea, 8'hbf, 8'h00, 8'hff);
      t_pins(8'h08, 8'h04, 8'h1f, 8'h40, 8'hff, 8'hff);
      t_timing();
      t_endian();
      tally_and_finish();
   end
endmodule : testbench
